// *** core/isc_pkg.sv ***
package isc_pkg;
   localparam logic [7:0]  STATUS_OFS      = 8'h58;
   localparam logic [7:0]  ENABLE_OFS      = 8'h5c;
   localparam logic [7:0]  BYTE_TEST_OFS   = 8'h64;
   localparam logic [31:0] BYTE_TEST_VAL   = 32'h87654321;
   localparam logic [31:0] STATUS_RST      = 32'h00000000;
   localparam logic [31:0] ENABLE_RST      = 32'h00000000;
   localparam logic [31:0] CLEARABLE_MASK  = 32'h83bbe7df;
   localparam logic [31:0] ENABLE_MASK     = 32'h83bfe7df;
   localparam int          SW_BIT          = 31;
   localparam int          TX_HALT_BIT     = 25;
   localparam int          RX_HALT_BIT     = 24;
   localparam int          DROP_HALF_BIT   = 23;
   localparam int          TX_DONE_BIT     = 21;
   localparam int          RX_COUNT_BIT    = 20;
   localparam int          TIMER_BIT       = 19;
   localparam int          PHY_BIT         = 18;
   localparam int          WAKE_BIT        = 17;
   localparam int          TX_SOVF_BIT     = 16;
   localparam int          OVERSIZE_BIT    = 15;
   localparam int          RX_FAULT_BIT    = 14;
   localparam int          TX_FAULT_BIT    = 13;
   localparam int          TX_OVR_BIT      = 10;
   localparam int          TX_SPACE_BIT    = 9;
   localparam int          TX_SFULL_BIT    = 8;
   localparam int          TX_SLVL_BIT     = 7;
   localparam int          DROP_BIT        = 6;
   localparam int          RX_SFULL_BIT    = 4;
   localparam int          RX_SLVL_BIT     = 3;
   localparam int          PIN_LSB         = 0;
   localparam int          PIN_COUNT       = 3;
   localparam logic [15:0] MAX_FRAME_BYTES = 16'd2048;
   localparam logic [31:0] DROP_HALF_FROM  = 32'h7fffffff;
   localparam logic [31:0] DROP_HALF_TO    = 32'h80000000;
   localparam logic [15:0] TIMER_FROM      = 16'h0000;
   localparam logic [15:0] TIMER_TO        = 16'hffff;

   typedef struct packed {
      logic tx_stop_req;
      logic tx_halted;
      logic rx_halted;
      logic tx_done_notify;
      logic rx_count_done;
      logic phy_irq;
      logic wake_detect;
      logic tx_status_ovf;
      logic rx_frame_end;
      logic rx_fault;
      logic tx_fault;
      logic tx_data_write;
      logic tx_data_full;
      logic tx_status_full;
      logic rx_status_full;
      logic frame_dropped;
   } isc_event_t;

   typedef struct packed {
      logic [31:0] drop_count;
      logic [15:0] timer_count;
      logic [15:0] rx_frame_len;
      logic [7:0]  tx_free_blocks;
      logic [7:0]  tx_space_level;
      logic [7:0]  tx_status_used;
      logic [7:0]  tx_status_level;
      logic [7:0]  rx_status_used;
      logic [7:0]  rx_status_level;
   } isc_level_t;

   typedef struct packed {
      logic [PIN_COUNT-1:0] rise_en;
      logic [PIN_COUNT-1:0] fall_en;
   } isc_pin_cfg_t;
endpackage : isc_pkg

// *** core/isc_top.sv ***
`timescale 1ns/10ps
module isc_top
   import isc_pkg::*;
(
   input  wire logic                 I_CLOCK,
   input  wire logic                 I_RST_N,
   input  wire logic                 i_WR,
   input  wire logic                 i_RD,
   input  wire logic [7:0]           i_ADDR,
   input  wire logic [31:0]          i_WDATA,
   input  wire isc_event_t           i_EVENT,
   input  wire isc_level_t           i_LEVEL,
   input  wire isc_pin_cfg_t         i_PIN_CFG,
   input  wire logic [PIN_COUNT-1:0] i_PIN,
   output logic [31:0]               o_RDATA,
   output logic                      o_MASTER_IRQ,
   output logic                      o_WAKE_IRQ,
   output logic                      o_WAKE_UP
);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   logic [31:0]          status_q, status_d;
   logic [31:0]          enable_q, enable_d;
   logic [31:0]          set_v;
   logic [31:0]          clr_v;
   logic [31:0]          drop_prev_q, drop_prev_d;
   logic [15:0]          timer_prev_q, timer_prev_d;
   logic                 drop_seen_q, drop_seen_d;
   logic [PIN_COUNT-1:0] pin_s1_q, pin_s2_q, pin_s3_q;
   logic [PIN_COUNT-1:0] pin_s1_d, pin_s2_d, pin_s3_d;
   logic [PIN_COUNT-1:0] pin_ev;
   logic [31:0]          rdata_d;
   logic                 master_d, wake_irq_d, wake_up_d;

   // event collection; level sources set every cycle they hold
   always_comb begin
      pin_ev = (pin_s2_q & ~pin_s3_q & i_PIN_CFG.rise_en)
             | (~pin_s2_q & pin_s3_q & i_PIN_CFG.fall_en);
      set_v = '0;
      set_v[SW_BIT]        = enable_q[SW_BIT];
      set_v[TX_HALT_BIT]   = i_EVENT.tx_stop_req & i_EVENT.tx_halted;
      set_v[RX_HALT_BIT]   = i_EVENT.rx_halted;
      set_v[DROP_HALF_BIT] = drop_seen_q && (drop_prev_q == DROP_HALF_FROM)
                          && (i_LEVEL.drop_count == DROP_HALF_TO);
      set_v[TX_DONE_BIT]   = i_EVENT.tx_done_notify;
      set_v[RX_COUNT_BIT]  = i_EVENT.rx_count_done;
      set_v[TIMER_BIT]     = drop_seen_q && (timer_prev_q == TIMER_FROM)
                          && (i_LEVEL.timer_count == TIMER_TO);
      // wake pin state is deliberately not an input here
      set_v[WAKE_BIT]      = i_EVENT.wake_detect;
      set_v[TX_SOVF_BIT]   = i_EVENT.tx_status_ovf;
      set_v[OVERSIZE_BIT]  = i_EVENT.rx_frame_end
                          && (i_LEVEL.rx_frame_len > MAX_FRAME_BYTES);
      set_v[RX_FAULT_BIT]  = i_EVENT.rx_fault;
      set_v[TX_FAULT_BIT]  = i_EVENT.tx_fault;
      set_v[TX_OVR_BIT]    = i_EVENT.tx_data_write & i_EVENT.tx_data_full;
      set_v[TX_SPACE_BIT]  = i_LEVEL.tx_free_blocks > i_LEVEL.tx_space_level;
      set_v[TX_SFULL_BIT]  = i_EVENT.tx_status_full;
      set_v[RX_SFULL_BIT]  = i_EVENT.rx_status_full;
      set_v[TX_SLVL_BIT]   = i_LEVEL.tx_status_used > i_LEVEL.tx_status_level;
      set_v[RX_SLVL_BIT]   = i_LEVEL.rx_status_used > i_LEVEL.rx_status_level;
      set_v[DROP_BIT]      = i_EVENT.frame_dropped;
      set_v[PIN_LSB +: PIN_COUNT] = pin_ev;
      clr_v = (i_WR && hit(i_ADDR, STATUS_OFS)) ? (i_WDATA & CLEARABLE_MASK) : '0;
      // set applied after clear so a coincident event survives
      status_d = ((status_q & ~clr_v) | set_v) & CLEARABLE_MASK;
      status_d[PHY_BIT] = i_EVENT.phy_irq;
      enable_d = (i_WR && hit(i_ADDR, ENABLE_OFS)) ? (i_WDATA & ENABLE_MASK) : enable_q;
      // history for the wrap detectors; arming avoids a false wrap out of reset
      drop_prev_d  = i_LEVEL.drop_count;
      timer_prev_d = i_LEVEL.timer_count;
      drop_seen_d  = 1'b1;
   end

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         status_q     <= STATUS_RST;
         enable_q     <= ENABLE_RST;
         drop_prev_q  <= '0;
         timer_prev_q <= '0;
         drop_seen_q  <= 1'b0;
      end else begin
         status_q     <= status_d;
         enable_q     <= enable_d;
         drop_prev_q  <= drop_prev_d;
         timer_prev_q <= timer_prev_d;
         drop_seen_q  <= drop_seen_d;
      end
   end

   // pin inputs are asynchronous; stage one feeds only stage two
   always_comb begin
      pin_s1_d = i_PIN;
      pin_s2_d = pin_s1_q;
      pin_s3_d = pin_s2_q;
   end

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
      end else begin
         pin_s1_q <= pin_s1_d;
         pin_s2_q <= pin_s2_d;
         pin_s3_q <= pin_s3_d;
      end
   end

   // outputs and read port
   always_comb begin
      rdata_d = '0;
      if (i_RD) begin
         case (1'b1)
            hit(i_ADDR, STATUS_OFS):    rdata_d = status_q;
            hit(i_ADDR, ENABLE_OFS):    rdata_d = enable_q;
            hit(i_ADDR, BYTE_TEST_OFS): rdata_d = BYTE_TEST_VAL;
            default:                    rdata_d = '0;
         endcase
      end
      master_d   = |(status_d & enable_d);
      // no hold-off path exists for the wake interrupt
      wake_irq_d = status_d[WAKE_BIT] & enable_d[WAKE_BIT];
      wake_up_d  = i_WR && hit(i_ADDR, BYTE_TEST_OFS);
   end

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         o_RDATA      <= '0;
         o_MASTER_IRQ <= 1'b0;
         o_WAKE_IRQ   <= 1'b0;
         o_WAKE_UP    <= 1'b0;
      end else begin
         o_RDATA      <= rdata_d;
         o_MASTER_IRQ <= master_d;
         o_WAKE_IRQ   <= wake_irq_d;
         o_WAKE_UP    <= wake_up_d;
      end
   end

   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RST_N);

   a_clear_by_one: assert property (
      (i_WR && i_ADDR == STATUS_OFS && i_WDATA[DROP_BIT] && !i_EVENT.frame_dropped)
      |=> !status_q[DROP_BIT]) else $error("write one did not clear flag");
   a_zero_keeps: assert property (
      (i_WR && i_ADDR == STATUS_OFS && !i_WDATA[TX_FAULT_BIT] && status_q[TX_FAULT_BIT])
      |=> status_q[TX_FAULT_BIT]) else $error("write zero changed flag");
   a_sw_set: assert property (
      enable_q[SW_BIT] |=> status_q[SW_BIT]) else $error("software flag not set");
   a_tx_halt: assert property (
      (i_EVENT.tx_stop_req && i_EVENT.tx_halted) |=> status_q[TX_HALT_BIT])
      else $error("transmit halted flag missing");
   a_drop_half: assert property (
      (i_LEVEL.drop_count == DROP_HALF_FROM) ##1 (i_LEVEL.drop_count == DROP_HALF_TO)
      |=> status_q[DROP_HALF_BIT]) else $error("drop half flag missing");
   a_timer_wrap: assert property (
      (i_LEVEL.timer_count == TIMER_FROM) ##1 (i_LEVEL.timer_count == TIMER_TO)
      |=> status_q[TIMER_BIT]) else $error("timer wrap flag missing");
   a_phy_mirror: assert property (
      status_q[PHY_BIT] == $past(i_EVENT.phy_irq)) else $error("phy flag not mirrored");
   a_oversize: assert property (
      (i_EVENT.rx_frame_end && i_LEVEL.rx_frame_len == MAX_FRAME_BYTES + 16'd1)
      |=> status_q[OVERSIZE_BIT]) else $error("oversize frame not flagged");
   a_exact_size: assert property (
      (i_EVENT.rx_frame_end && i_LEVEL.rx_frame_len == MAX_FRAME_BYTES
       && !status_q[OVERSIZE_BIT])
      |=> !status_q[OVERSIZE_BIT]) else $error("2048 byte frame flagged");
   a_pin_rise: assert property (
      (pin_s2_q[0] && !pin_s3_q[0] && i_PIN_CFG.rise_en[0])
      |=> status_q[PIN_LSB]) else $error("pin edge lost");
   a_set_wins: assert property (
      (i_WR && i_ADDR == STATUS_OFS && i_WDATA[RX_FAULT_BIT] && i_EVENT.rx_fault)
      |=> status_q[RX_FAULT_BIT]) else $error("coincident event lost");
   a_reserved_zero: assert property (
      (status_q & ~(CLEARABLE_MASK | (32'h1 << PHY_BIT))) == '0)
      else $error("reserved bit set");
   a_master_irq: assert property (
      o_MASTER_IRQ == |(status_q & enable_q)) else $error("master indication wrong");
   a_wake_only_byte: assert property (
      o_WAKE_UP |-> $past(i_WR && i_ADDR == BYTE_TEST_OFS)) else $error("spurious wake");
   a_wake_flag: assert property (
      i_EVENT.wake_detect |=> status_q[WAKE_BIT] && (o_WAKE_IRQ == enable_q[WAKE_BIT]))
      else $error("wake flag or interrupt missing");
   a_half_stop: assert property (
      (i_EVENT.tx_halted && !i_EVENT.tx_stop_req && !status_q[TX_HALT_BIT])
      |=> !status_q[TX_HALT_BIT]) else $error("halt without stop request flagged");
   a_rx_halt: assert property (
      i_EVENT.rx_halted |=> status_q[RX_HALT_BIT])
      else $error("receive halted flag missing");
   a_tx_done: assert property (
      i_EVENT.tx_done_notify |=> status_q[TX_DONE_BIT])
      else $error("transmit done flag missing");
   a_rx_count: assert property (
      i_EVENT.rx_count_done |=> status_q[RX_COUNT_BIT])
      else $error("receive count flag missing");
   a_wake_clear: assert property (
      (i_WR && i_ADDR == STATUS_OFS && i_WDATA[WAKE_BIT] && !i_EVENT.wake_detect)
      |=> !status_q[WAKE_BIT]) else $error("wake flag not cleared");
   a_wake_up_pulse: assert property (
      (i_WR && i_ADDR == BYTE_TEST_OFS) |=> o_WAKE_UP)
      else $error("byte test write did not wake");
   a_wake_irq_now: assert property (
      o_WAKE_IRQ == (status_q[WAKE_BIT] && enable_q[WAKE_BIT]))
      else $error("wake interrupt delayed");
   a_tx_sovf: assert property (
      i_EVENT.tx_status_ovf |=> status_q[TX_SOVF_BIT])
      else $error("status overflow flag missing");
   a_rx_fault: assert property (
      i_EVENT.rx_fault |=> status_q[RX_FAULT_BIT])
      else $error("receive fault flag missing");
   a_tx_fault: assert property (
      i_EVENT.tx_fault |=> status_q[TX_FAULT_BIT])
      else $error("transmit fault flag missing");
   a_tx_overrun: assert property (
      (i_EVENT.tx_data_write && i_EVENT.tx_data_full) |=> status_q[TX_OVR_BIT])
      else $error("overrun flag missing");
   a_overrun_needs_full: assert property (
      (i_EVENT.tx_data_write && !i_EVENT.tx_data_full && !status_q[TX_OVR_BIT])
      |=> !status_q[TX_OVR_BIT]) else $error("overrun flagged without full");
   a_tx_space: assert property (
      (i_LEVEL.tx_free_blocks > i_LEVEL.tx_space_level) |=> status_q[TX_SPACE_BIT])
      else $error("space available flag missing");
   a_tx_full: assert property (
      i_EVENT.tx_status_full |=> status_q[TX_SFULL_BIT])
      else $error("transmit status full flag missing");
   a_rx_full: assert property (
      i_EVENT.rx_status_full |=> status_q[RX_SFULL_BIT])
      else $error("receive status full flag missing");
   a_tx_level: assert property (
      (i_LEVEL.tx_status_used > i_LEVEL.tx_status_level) |=> status_q[TX_SLVL_BIT])
      else $error("transmit status level flag missing");
   a_rx_level: assert property (
      (i_LEVEL.rx_status_used > i_LEVEL.rx_status_level) |=> status_q[RX_SLVL_BIT])
      else $error("receive status level flag missing");
   a_frame_drop: assert property (
      i_EVENT.frame_dropped |=> status_q[DROP_BIT])
      else $error("dropped frame flag missing");
   a_pin_fall: assert property (
      (!pin_s2_q[2] && pin_s3_q[2] && i_PIN_CFG.fall_en[2])
      |=> status_q[PIN_LSB + 2]) else $error("pin fall lost");
   a_flag_unmasked: assert property (
      (i_EVENT.frame_dropped && !enable_q[DROP_BIT]) |=> status_q[DROP_BIT])
      else $error("masked flag not recorded");
   a_sw_clear: assert property (
      (i_WR && i_ADDR == STATUS_OFS && i_WDATA[SW_BIT] && !enable_q[SW_BIT])
      |=> !status_q[SW_BIT]) else $error("software flag not cleared");
   a_enable_write: assert property (
      (i_WR && i_ADDR == ENABLE_OFS) |=> (enable_q == ($past(i_WDATA) & ENABLE_MASK)))
      else $error("enable write wrong");
   a_read_status: assert property (
      (i_RD && i_ADDR == STATUS_OFS) |=> (o_RDATA == $past(status_q)))
      else $error("status read wrong");
   a_read_idle: assert property (
      !$past(i_RD) |-> (o_RDATA == '0)) else $error("read data outside read");

   c_clear_flag: cover property (i_WR && i_ADDR == STATUS_OFS && |status_q);
   c_set_wins: cover property (i_EVENT.frame_dropped && i_WR && i_ADDR == STATUS_OFS
      && i_WDATA[DROP_BIT]);
   c_master_up: cover property ($rose(o_MASTER_IRQ));
   c_wake_write: cover property (o_WAKE_UP);
   c_pin_event: cover property (|pin_ev);
endmodule : isc_top

// *** verif/irq_status_collector_tb.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module irq_status_collector_tb
   import isc_pkg::*;
;
   logic                 clk;
   logic                 rst_n;
   logic                 wr;
   logic                 rd;
   logic [7:0]           addr;
   logic [31:0]          wdata;
   logic [31:0]          rdata;
   isc_event_t           ev;
   isc_level_t           lv;
   isc_pin_cfg_t         pcfg;
   logic [PIN_COUNT-1:0] pin;
   logic                 mirq;
   logic                 wirq;
   logic                 wake;
   int                   num_errors = 0;
   int                   compares = 0;

   isc_top dut (.I_CLOCK(clk), .I_RST_N(rst_n), .i_WR(wr), .i_RD(rd), .i_ADDR(addr),
      .i_WDATA(wdata), .i_EVENT(ev), .i_LEVEL(lv), .i_PIN_CFG(pcfg), .i_PIN(pin),
      .o_RDATA(rdata), .o_MASTER_IRQ(mirq), .o_WAKE_IRQ(wirq), .o_WAKE_UP(wake));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic print_verdict();
      if (num_errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask : rd_chk

   task automatic pulse(input isc_event_t e);
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= '0;
   endtask : pulse

   // hang guard: the main sequence needs well under this many cycles
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      print_verdict();
   end

   initial begin
      isc_event_t e;
      rst_n = 1'b0;
      wr    = 1'b0;
      rd    = 1'b0;
      addr  = '0;
      wdata = '0;
      ev    = '0;
      lv    = '0;
      pcfg  = '0;
      pin   = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(STATUS_OFS, STATUS_RST);
      rd_chk(ENABLE_OFS, ENABLE_RST);
      rd_chk(8'h60, 32'h0);
      rd_chk(BYTE_TEST_OFS, BYTE_TEST_VAL);
      // read data stands one cycle only
      @(posedge clk);
      #1;
      `CHK(rdata, 32'h0)
      // half conditions alone must not latch anything
      e = '0;
      e.tx_halted = 1'b1;
      e.tx_data_write = 1'b1;
      pulse(e);
      rd_chk(STATUS_OFS, 32'h0);
      e = 16'hffff;
      e.phy_irq = 1'b0;
      e.rx_frame_end = 1'b0;
      pulse(e);
      #1;
      `CHK(mirq, 1'b0)
      rd_chk(STATUS_OFS, 32'h03336550);
      wr_reg(STATUS_OFS, 32'h0);
      rd_chk(STATUS_OFS, 32'h03336550);
      wr_reg(STATUS_OFS, 32'h00000040);
      rd_chk(STATUS_OFS, 32'h03336510);
      wr_reg(STATUS_OFS, 32'hffffffff);
      rd_chk(STATUS_OFS, 32'h0);
      // counters and fills at their boundaries, then one step past them
      e = '0;
      e.rx_frame_end = 1'b1;
      @(posedge clk);
      lv <= '{32'h7fffffff, 16'h0, 16'd2048, 8'd5, 8'd5, 8'd5, 8'd5, 8'd5, 8'd5};
      pulse(e);
      rd_chk(STATUS_OFS, 32'h0);
      @(posedge clk);
      lv <= '{32'h80000000, 16'hffff, 16'd2049, 8'd6, 8'd5, 8'd6, 8'd5, 8'd6, 8'd5};
      pulse(e);
      lv <= '0;
      rd_chk(STATUS_OFS, 32'h00888288);
      wr_reg(STATUS_OFS, 32'hffffffff);
      rd_chk(STATUS_OFS, 32'h0);
      // transceiver flag follows its source only
      e = '0;
      e.phy_irq = 1'b1;
      @(posedge clk);
      ev <= e;
      wr_reg(STATUS_OFS, 32'h00040000);
      rd_chk(STATUS_OFS, 32'h00040000);
      @(posedge clk);
      ev <= '0;
      rd_chk(STATUS_OFS, 32'h0);
      wr_reg(ENABLE_OFS, 32'hffffffff);
      rd_chk(ENABLE_OFS, ENABLE_MASK);
      rd_chk(STATUS_OFS, 32'h80000000);
      `CHK(mirq, 1'b1)
      wr_reg(ENABLE_OFS, 32'h00020000);
      wr_reg(STATUS_OFS, 32'h80000000);
      rd_chk(STATUS_OFS, 32'h0);
      `CHK(mirq, 1'b0)
      e = '0;
      e.wake_detect = 1'b1;
      pulse(e);
      #1;
      `CHK(wirq, 1'b1)
      `CHK(mirq, 1'b1)
      `CHK(wake, 1'b0)
      wr_reg(BYTE_TEST_OFS, 32'h0);
      #1;
      `CHK(wake, 1'b1)
      rd_chk(BYTE_TEST_OFS, BYTE_TEST_VAL);
      `CHK(wake, 1'b0)
      wr_reg(STATUS_OFS, 32'h00020000);
      #1;
      `CHK(wirq, 1'b0)
      // event and clear on the same edge: the event must survive
      e = '0;
      e.frame_dropped = 1'b1;
      @(posedge clk);
      ev    <= e;
      wr    <= 1'b1;
      addr  <= STATUS_OFS;
      wdata <= 32'h00000040;
      @(posedge clk);
      ev <= '0;
      wr <= 1'b0;
      rd_chk(STATUS_OFS, 32'h00000040);
      wr_reg(STATUS_OFS, 32'h00000040);
      @(posedge clk);
      pcfg <= '{3'b011, 3'b100};
      pin  <= 3'b111;
      repeat (5) @(posedge clk);
      rd_chk(STATUS_OFS, 32'h00000003);
      wr_reg(STATUS_OFS, 32'h7);
      pin <= 3'b000;
      repeat (5) @(posedge clk);
      rd_chk(STATUS_OFS, 32'h00000004);
      // reset in mid-run with flags and enables set clears everything
      wr_reg(ENABLE_OFS, 32'h00000040);
      e = '0;
      e.frame_dropped = 1'b1;
      pulse(e);
      #1;
      `CHK(mirq, 1'b1)
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      `CHK(mirq, 1'b0)
      rd_chk(STATUS_OFS, STATUS_RST);
      rd_chk(ENABLE_OFS, ENABLE_RST);
      print_verdict();
   end
endmodule : irq_status_collector_tb
